// ==== crs_core_regs.sv ====
// dedicated register set, flag logic and banked registers of the core
// Overview of operation
// - 16-bit instruction pointer, reset to fffd
// - primary work word, low byte for bytes
// - second operand word joins arithmetic, low byte
// - index word offsets indexed operand addresses
// - extra pointer holds data memory address
// - stack pointer addresses current stack area
// - status word: bank select high, flags low
// - nibble carry on bit3 to bit4
// - interrupts only while enable flag set
// - take request only when level number is below threshold
// - reset sets threshold 11, enable 0
// - negative flag follows result msb
// - zero flag on zero result
// - overflow flag on two's complement overflow
// - carry flag on carry out of bit7
// - shifts load carry with shifted-out bit
// - byte registers in memory, eight per bank
// - bank count is a build parameter
// - bank select picks active register bank
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs
  import crs_pkg::*;
#(
  parameter int BANKS = 32
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // software register port
  input  wire crs_pkg::crs_bus_req_t bus_req,
  output var  logic [15:0]        bus_rdata,
  // core side
  input  wire crs_pkg::crs_alu_req_t alu_req,
  input  wire logic               ip_step,
  input  wire logic [7:0]         ix_disp,
  input  wire logic [2:0]         gpr_index,
  // interrupt request
  input  wire logic               irq_req,
  input  wire logic [1:0]         irq_level,
  output var  logic               irq_take,
  // pointer and bank view
  output var  crs_pkg::crs_view_t view
);
  import crs_pkg::*;

  localparam int BANK_BITS = $clog2(BANKS);

  typedef struct packed {
    logic [15:0] ip;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [7:0]  bank;
    logic [7:0]  flags;
    logic [15:0] rdata;
    logic        take;
    crs_view_t   view;
    logic [CRS_GPR_BYTES-1:0][7:0] gpr;
  } crs_state_t;

  crs_state_t s_q;
  crs_state_t s_d;

  // bank base: consecutive groups of eight bytes, wrapped to the bank count
  function automatic logic [7:0] crs_bank_base(input logic [7:0] sel);
    logic [BANK_BITS-1:0] b;
    b = sel[BANK_BITS-1:0];
    crs_bank_base = 8'(CRS_BANK_ORIGIN + 8'(b) * 8'(CRS_REGS_PER_BANK));
  endfunction

  logic [7:0] a8;
  logic [7:0] b8;
  logic [8:0] sum9;
  logic [8:0] dif9;
  logic [4:0] nib;
  logic [7:0] res;
  logic       res_c;
  logic       res_h;
  logic       res_v;
  logic       arith;
  logic [7:0] base;
  logic [7:0] gaddr;

  always_comb begin
    a8    = s_q.acc[7:0];
    b8    = s_q.tmp[7:0];
    sum9  = {1'b0, a8} + {1'b0, b8};
    dif9  = {1'b0, a8} - {1'b0, b8};
    nib   = 5'({1'b0, a8[3:0]} + {1'b0, b8[3:0]});
    res   = 8'h00;
    res_c = 1'b0;
    res_h = s_q.flags[CRS_F_H];
    res_v = s_q.flags[CRS_F_V];
    arith = 1'b0;
    case (alu_req.op)
      CRS_OP_ADD: begin
        res   = sum9[7:0];
        res_c = sum9[8];
        res_h = nib[4];
        res_v = (a8[7] == b8[7]) && (sum9[7] != a8[7]);
        arith = 1'b1;
      end
      CRS_OP_SUB: begin
        res   = dif9[7:0];
        res_c = dif9[8];
        res_h = a8[3:0] < b8[3:0];
        res_v = (a8[7] != b8[7]) && (dif9[7] != a8[7]);
        arith = 1'b1;
      end
      CRS_OP_SHL: begin
        res   = {a8[6:0], 1'b0};
        res_c = a8[7];
      end
      CRS_OP_SHR: begin
        res   = {1'b0, a8[7:1]};
        res_c = a8[0];
      end
      default: begin
        res   = a8;
        res_c = s_q.flags[CRS_F_C];
      end
    endcase
  end

  always_comb begin
    s_d   = s_q;
    base  = crs_bank_base(s_q.bank);
    gaddr = 8'(base + 8'(gpr_index));

    // instruction pointer steps through instruction storage
    if (ip_step) begin
      s_d.ip = 16'(s_q.ip + 16'h0001);
    end

    // software writes; a write and an arithmetic step in one cycle both land,
    // the arithmetic result wins on the fields it touches
    if (bus_req.we) begin
      if (bus_req.addr[CRS_GPR_BIT]) begin
        s_d.gpr[bus_req.addr[CRS_GPR_BIT-1:0]] = bus_req.wdata[7:0];
      end else begin
        case (bus_req.addr)
          CRS_IDX_IP:  s_d.ip  = bus_req.wdata;
          CRS_IDX_ACC: s_d.acc = bus_req.wdata;
          CRS_IDX_TMP: s_d.tmp = bus_req.wdata;
          CRS_IDX_IX:  s_d.ix  = bus_req.wdata;
          CRS_IDX_EP:  s_d.ep  = bus_req.wdata;
          CRS_IDX_SP:  s_d.sp  = bus_req.wdata;
          CRS_IDX_PS: begin
            s_d.bank  = bus_req.wdata[15:8];
            s_d.flags = bus_req.wdata[7:0];
          end
          default: s_d.ip = s_d.ip;
        endcase
      end
    end

    // byte arithmetic on the low bytes, result back into the work word
    if (alu_req.valid) begin
      s_d.acc[7:0]        = res;
      s_d.flags[CRS_F_C]  = res_c;
      s_d.flags[CRS_F_N]  = res[7];
      s_d.flags[CRS_F_Z]  = (res == 8'h00);
      if (arith) begin
        s_d.flags[CRS_F_H] = res_h;
        s_d.flags[CRS_F_V] = res_v;
      end
    end

    // read data stands only in the cycle after the read strobe
    s_d.rdata = 16'h0000;
    if (bus_req.re) begin
      if (bus_req.addr[CRS_GPR_BIT]) begin
        s_d.rdata = {8'h00, s_q.gpr[bus_req.addr[CRS_GPR_BIT-1:0]]};
      end else begin
        case (bus_req.addr)
          CRS_IDX_IP:   s_d.rdata = s_q.ip;
          CRS_IDX_ACC:  s_d.rdata = s_q.acc;
          CRS_IDX_TMP:  s_d.rdata = s_q.tmp;
          CRS_IDX_IX:   s_d.rdata = s_q.ix;
          CRS_IDX_EP:   s_d.rdata = s_q.ep;
          CRS_IDX_SP:   s_d.rdata = s_q.sp;
          CRS_IDX_PS:   s_d.rdata = {s_q.bank, s_q.flags};
          CRS_IDX_STAT: s_d.rdata = {8'h00, base};
          default:      s_d.rdata = 16'h0000;
        endcase
      end
    end

    // lower level number means higher priority
    s_d.take = irq_req && s_q.flags[CRS_F_I]
               && (irq_level < {s_q.flags[CRS_F_IL1], s_q.flags[CRS_F_IL0]});

    // registered view of the pointers for the address path
    s_d.view.ip        = s_q.ip;
    s_d.view.sp        = s_q.sp;
    s_d.view.ep        = s_q.ep;
    s_d.view.ix_eff    = 16'(s_q.ix + {{8{ix_disp[7]}}, ix_disp});
    s_d.view.bank_base = base;
    // full byte address, so banks above the software window are still reached
    s_d.view.gpr_data  = s_q.gpr[gaddr];
  end

  // undefined reset fields are cleared so simulation stays free of unknowns
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q                 <= '0;
      s_q.ip              <= CRS_RST_IP;
      s_q.acc             <= CRS_RST_WORD;
      s_q.flags[CRS_F_I]  <= CRS_RST_IE;
      s_q.flags[CRS_F_IL1] <= CRS_RST_IL[1];
      s_q.flags[CRS_F_IL0] <= CRS_RST_IL[0];
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  assign irq_take  = s_q.take;
  assign view      = s_q.view;

endmodule
`default_nettype wire

// ==== crs_core_regs_checker.sv ====
// port assertions for the core register set
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs_checker
  import crs_pkg::*;
#(parameter int BANKS = 32) (
  // watched ports
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire crs_pkg::crs_bus_req_t bus_req,
  input wire logic [15:0]           bus_rdata,
  input wire logic                  ip_step,
  input wire logic [7:0]            ix_disp,
  input wire logic                  irq_req,
  input wire logic [1:0]            irq_level,
  input wire logic                  irq_take,
  input wire crs_pkg::crs_view_t    view
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // two cycles with no register write, so pointers can only move on their own
  sequence s_quiet; !bus_req.we [*2]; endsequence
  sequence s_step; ip_step && !(bus_req.we && bus_req.addr == CRS_IDX_IP); endsequence
  a_ip_step: assert property (s_step |=> ##1 view.ip == $past(view.ip) + 16'h0001) else $error("ip step lost");
  a_ix_disp: assert property (s_quiet |=> view.ix_eff - $past(view.ix_eff) == {{8{$past(ix_disp[7])}}, $past(ix_disp)}
    - {{8{$past(ix_disp[7], 2)}}, $past(ix_disp, 2)}) else $error("index offset wrong");
  a_ptr_hold: assert property (s_quiet |=> $stable(view.sp) && $stable(view.ep)) else $error("pointer moved");
  a_bank_align: assert property (view.bank_base[2:0] == 3'h0) else $error("bank base unaligned");
  a_bank_range: assert property (int'(view.bank_base) < BANKS * 8) else $error("bank beyond count");
  a_stat_align: assert property ($past(bus_req.re) && $past(bus_req.addr) == CRS_IDX_STAT |-> bus_rdata[2:0] == 3'h0)
    else $error("bank read unaligned");
  a_irq_none: assert property (!irq_req |=> !irq_take) else $error("take without request");
  a_irq_lowest: assert property (irq_level == 2'h3 |=> !irq_take) else $error("lowest level taken");
endmodule
bind crs_core_regs crs_core_regs_checker #(.BANKS(BANKS)) crs_core_regs_checker_inst (.mclk, .rst, .bus_req,
  .bus_rdata, .ip_step, .ix_disp, .irq_req, .irq_level, .irq_take, .view);
`default_nettype wire

// ==== crs_pkg.sv ====
// constants and carriers shared by the core register set
package crs_pkg;

  // register indices on the software port
  localparam logic [7:0] CRS_IDX_IP   = 8'h00;
  localparam logic [7:0] CRS_IDX_ACC  = 8'h01;
  localparam logic [7:0] CRS_IDX_TMP  = 8'h02;
  localparam logic [7:0] CRS_IDX_IX   = 8'h03;
  localparam logic [7:0] CRS_IDX_EP   = 8'h04;
  localparam logic [7:0] CRS_IDX_SP   = 8'h05;
  localparam logic [7:0] CRS_IDX_PS   = 8'h06;
  localparam logic [7:0] CRS_IDX_STAT = 8'h07;
  localparam logic [7:0] CRS_GPR_BASE = 8'h80;
  localparam int         CRS_GPR_BIT  = 7;

  // reset values
  localparam logic [15:0] CRS_RST_IP   = 16'hfffd;
  localparam logic [15:0] CRS_RST_WORD = 16'h0000;
  localparam logic [1:0]  CRS_RST_IL   = 2'h3;
  localparam logic        CRS_RST_IE   = 1'h0;

  // flag positions inside the flag byte
  localparam int CRS_F_H   = 7;
  localparam int CRS_F_I   = 6;
  localparam int CRS_F_IL1 = 5;
  localparam int CRS_F_IL0 = 4;
  localparam int CRS_F_N   = 3;
  localparam int CRS_F_Z   = 2;
  localparam int CRS_F_V   = 1;
  localparam int CRS_F_C   = 0;

  // banked registers
  localparam int          CRS_REGS_PER_BANK = 8;
  localparam int          CRS_MAX_BANKS     = 32;
  localparam int          CRS_GPR_BYTES     = CRS_REGS_PER_BANK * CRS_MAX_BANKS;
  localparam logic [7:0]  CRS_BANK_ORIGIN   = 8'h00;

  typedef enum logic [1:0] {
    CRS_OP_ADD = 2'b00,
    CRS_OP_SUB = 2'b01,
    CRS_OP_SHL = 2'b10,
    CRS_OP_SHR = 2'b11
  } crs_op_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } crs_bus_req_t;

  typedef struct packed {
    logic    valid;
    crs_op_t op;
  } crs_alu_req_t;

  typedef struct packed {
    logic [15:0] ip;
    logic [15:0] sp;
    logic [15:0] ep;
    logic [15:0] ix_eff;
    logic [7:0]  bank_base;
    logic [7:0]  gpr_data;
  } crs_view_t;

endpackage

// ==== tb.sv ====
// self-checking bench for the core register set
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crs_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] t;
    crs_op_t     op;
    logic [15:0] ps;
    logic [15:0] ra;
    logic [15:0] rps;
  } crs_row_t;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  crs_bus_req_t bus_req = '0;
  logic [15:0]  bus_rdata;
  crs_alu_req_t alu_req = '0;
  logic         ip_step = 1'b0;
  logic [7:0]   ix_disp = 8'h00;
  logic [2:0]   gpr_index = 3'h0;
  logic         irq_req = 1'b0;
  logic [1:0]   irq_level = 2'h0;
  logic         irq_take;
  crs_view_t    view;
  int           err_count = 0;
  int           check_count = 0;
  crs_row_t     rows [8];
  always #2 mclk = ~mclk;
  // eight banks so the selector wraps inside the test
  crs_core_regs #(.BANKS(8)) crs_core_regs_inst (.mclk, .rst, .bus_req, .bus_rdata, .alu_req, .ip_step,
    .ix_disp, .gpr_index, .irq_req, .irq_level, .irq_take, .view);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [15:0] d, input logic w);
    @(posedge mclk) bus_req <= {a, d, w, ~w};
    @(posedge mclk) bus_req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    bus(a, 16'h0000, 1'b0);
    chk(bus_rdata, exp);
  endtask
  task automatic alu(input crs_op_t op);
    @(posedge mclk) alu_req <= {1'b1, op};
    @(posedge mclk) alu_req <= '0;
  endtask
  task automatic irq(input logic [15:0] ps, input logic [1:0] lvl, input logic exp);
    bus(CRS_IDX_PS, ps, 1'b1);
    @(posedge mclk) begin
      irq_req <= 1'b1;
      irq_level <= lvl;
    end
    @(posedge mclk) #1;
    chk({15'h0, irq_take}, {15'h0, exp});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge mclk);
    err_count++;
    test_done;
  end
  initial begin
    rows[0] = '{16'h120f, 16'h0001, CRS_OP_ADD, 16'h0030, 16'h1210, 16'h00b0};
    rows[1] = '{16'h3480, 16'h0080, CRS_OP_ADD, 16'h0030, 16'h3400, 16'h0037};
    rows[2] = '{16'h007f, 16'h0001, CRS_OP_ADD, 16'h0030, 16'h0080, 16'h00ba};
    rows[3] = '{16'h0010, 16'h0001, CRS_OP_SUB, 16'h0030, 16'h000f, 16'h00b0};
    rows[4] = '{16'h0000, 16'h0001, CRS_OP_SUB, 16'h0030, 16'h00ff, 16'h00b9};
    rows[5] = '{16'h0080, 16'h0001, CRS_OP_SUB, 16'h0030, 16'h007f, 16'h00b2};
    rows[6] = '{16'h5581, 16'h0000, CRS_OP_SHL, 16'h0082, 16'h5502, 16'h0083};
    rows[7] = '{16'haa01, 16'h0000, CRS_OP_SHR, 16'h0030, 16'haa00, 16'h0035};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(CRS_IDX_ACC, rows[i].a, 1'b1);
      bus(CRS_IDX_TMP, rows[i].t, 1'b1);
      bus(CRS_IDX_PS, rows[i].ps, 1'b1);
      alu(rows[i].op);
      rd(CRS_IDX_ACC, rows[i].ra);
      rd(CRS_IDX_PS, rows[i].rps);
    end
    $display("alu table done");
    for (int i = 1; i < 6; i++) bus(i[7:0], {8'ha0 + i[7:0], 8'h5c}, 1'b1);
    for (int i = 1; i < 6; i++) rd(i[7:0], {8'ha0 + i[7:0], 8'h5c});
    chk(view.ep, 16'ha45c);
    chk(view.sp, 16'ha55c);
    bus(8'h08, 16'hffff, 1'b1);
    rd(8'h08, 16'h0000);
    rd(8'h7f, 16'h0000);
    $display("word registers done");
    bus(CRS_IDX_IP, 16'h1000, 1'b1);
    @(posedge mclk) ip_step <= 1'b1;
    repeat (3) @(posedge mclk);
    ip_step <= 1'b0;
    rd(CRS_IDX_IP, 16'h1003);
    bus(CRS_IDX_IX, 16'h1000, 1'b1);
    @(posedge mclk) ix_disp <= 8'hfe;
    repeat (2) @(posedge mclk) #1;
    chk(view.ix_eff, 16'h0ffe);
    $display("pointers done");
    // selector 0x0b wraps to bank 3 with eight banks
    bus(CRS_IDX_PS, 16'h0b00, 1'b1);
    bus(8'h9d, 16'h1234, 1'b1);
    @(posedge mclk) gpr_index <= 3'h5;
    repeat (2) @(posedge mclk) #1;
    chk({8'h00, view.bank_base}, 16'h0018);
    chk({8'h00, view.gpr_data}, 16'h0034);
    rd(CRS_IDX_STAT, 16'h0018);
    rd(8'h9d, 16'h0034);
    $display("banks done");
    irq(16'h0b60, 2'h0, 1'b1);
    irq(16'h0b60, 2'h1, 1'b1);
    irq(16'h0b60, 2'h2, 1'b0);
    irq(16'h0b20, 2'h0, 1'b0);
    irq(16'h0b70, 2'h2, 1'b1);
    irq(16'h0b70, 2'h3, 1'b0);
    @(posedge mclk) irq_req <= 1'b0;
    $display("interrupt gating done");
    @(posedge mclk) rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(CRS_IDX_IP, 16'hfffd);
    chk(view.ip, 16'hfffd);
    rd(CRS_IDX_PS, 16'h0030);
    $display("reset done");
    test_done;
  end
endmodule
`default_nettype wire
